// >>> common/pss_mem_if.sv
// Carrier between the memory controller core and the storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pss_mem_if;
	import pss_pkg::*;

	logic                    rd_en;
	logic [PSS_ADDR_W-1:0]   rd_addr;
	logic [PSS_WORD_W-1:0]   rd_data;
	logic                    wr_en;
	logic [PSS_ADDR_W-1:0]   wr_addr;
	logic [PSS_LANES-1:0]    wr_lane;
	logic [PSS_WORD_W-1:0]   wr_data;

	modport ctrl (output rd_en, output rd_addr, input rd_data,
	              output wr_en, output wr_addr, output wr_lane, output wr_data);
	modport mem  (input rd_en, input rd_addr, output rd_data,
	              input wr_en, input wr_addr, input wr_lane, input wr_data);

endinterface : pss_mem_if

// >>> common/pss_pkg.sv
// Constants, types and helpers for the pipelined late-write static memory.
// Assumes one clock; the controller drives all synchronous pins from that clock.
//
// What this block does
// - Array of 2,097,152 words, 18 bits each, on one shared data bus.
// - The same two-way bus carries write data in and read data out.
// - Read data driven two cycles after command; write data latency matches.
// - Write data is captured two cycles after its command and address.
// - Reads and writes mix on consecutive cycles with no idle bus cycle.
// - Each lane enable gates its lane; all enables low writes the full word.
// - Write command, lane enables and address are registered on one rising edge.
// - Output enable acts asynchronously on drivers; may stay low permanently.
// - Any one of three chip selects deselecting releases the data bus.
// - Deselect takes two cycles so pipelined operations complete first.
// - Advance high ignores address, selects, direction; steps burst counter.
// - Clock hold high stalls every register except the burst order synchroniser, bursts and pipeline included.
// - Two lowest address bits seed the counter; bursts change only them.
// - Interleaved and linear burst sequences, chosen by burst order select.
// - Order select low gives linear; high gives interleaved.
// - Read-not-write high at load starts a read.
// - Advance low with chip enabled loads a new address and command.
package pss_pkg;

	localparam int PSS_ADDR_W    = 21;
	localparam int PSS_DEPTH     = 2097152;
	localparam int PSS_LANE_W    = 9;
	localparam int PSS_LANES     = 2;
	localparam int PSS_WORD_W    = PSS_LANE_W * PSS_LANES;
	localparam int PSS_DATA_BITS = 8;
	localparam int PSS_BURST_W   = 2;
	localparam int PSS_PIPE_LAT  = 2;

	localparam logic [PSS_BURST_W-1:0] PSS_BURST_ZERO = 2'h0;
	localparam logic [PSS_BURST_W-1:0] PSS_BURST_ONE  = 2'h1;
	localparam logic                   PSS_ORDER_RST  = 1'h1;

	typedef enum logic [1:0] {
		PSS_OP_IDLE,
		PSS_OP_READ,
		PSS_OP_WRITE
	} pss_op_t;

	// Burst low bits: interleaved XOR, linear add, both wrap in four
	function automatic logic [PSS_BURST_W-1:0] pss_burst_low(
		input logic [PSS_BURST_W-1:0] seed,
		input logic [PSS_BURST_W-1:0] cnt,
		input logic                   interleaved
	);
		pss_burst_low = interleaved ? (seed ^ cnt) : PSS_BURST_W'(seed + cnt);
	endfunction : pss_burst_low

endpackage : pss_pkg

// >>> tb/pss_ctrl_model.sv
// Controller model: puts late write data on the shared data bus.
// Assumes the bench issues commands and marks each write slot on wr_issue.
`timescale 1ns/1ps
module pss_ctrl_model
	import pss_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clock_hold_n,
	input  wire logic                  wr_issue,
	input  wire logic [PSS_WORD_W-1:0] wr_word,
	output logic      [PSS_WORD_W-1:0] bus_word
);
	// ==========
	// Write slot pipeline, frozen by clock hold
	logic [PSS_WORD_W:0] slot0_reg;
	logic [PSS_WORD_W:0] slot1_reg;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			slot0_reg <= '0;
			slot1_reg <= '0;
		end else if (!clock_hold_n) begin
			slot0_reg <= {wr_issue, wr_word};
			slot1_reg <= slot0_reg;
		end
	end
	// Released bus shows a changing pattern
	always @(negedge ref_clk) begin
		if (sys_rst) begin
			bus_word <= '0;
		end else begin
			bus_word <= slot1_reg[PSS_WORD_W] ? slot1_reg[PSS_WORD_W-1:0] : ~bus_word;
		end
	end
endmodule : pss_ctrl_model

// >>> tb/pss_sram_tb_top.sv
// Testbench for the pipelined late-write static memory.
// Assumes pss_sram and the controller model; one 40 MHz clock.
`timescale 1ns/1ps
module pss_sram_tb_top
	import pss_pkg::*;
;
	localparam int OP_RD = 0, OP_WR = 1, OP_BST = 2, OP_DES = 3;
	typedef struct {int t; logic [PSS_WORD_W-1:0] d;} pss_due_t;
	logic ref_clk = 1'b0;
	logic sys_rst, clock_hold_n, chip_select_first, chip_select_second, chip_select_third;
	logic advance_or_load, read_not_write, lane_low_write_en_n, lane_high_write_en_n;
	logic output_enable_n, burst_order_select, burst_seed_bit1, burst_seed_bit0, wr_issue;
	logic [PSS_ADDR_W-3:0] address_upper;
	logic [PSS_WORD_W-1:0] bus_word, wr_word, exp_d;
	wire  [PSS_WORD_W-1:0] got;
	wire                   data_bus_oe;
	int n_mismatch = 0, tests_run = 0, run_cnt = 0, seen = 0, last_op;
	logic                  hit = 1'b0;
	logic                  ord;
	logic [PSS_ADDR_W-1:0] base;
	logic [1:0]            cnt;
	logic [PSS_WORD_W-1:0] shadow [int];
	pss_due_t              due [$];

	always #12.5 ref_clk = ~ref_clk;

	pss_sram uut (.ref_clk, .sys_rst, .clock_hold_n, .chip_select_first, .chip_select_second,
		.chip_select_third, .advance_or_load, .read_not_write, .lane_low_write_en_n,
		.lane_high_write_en_n, .output_enable_n, .burst_order_select, .address_upper,
		.burst_seed_bit1, .burst_seed_bit0, .data_lane_low_in(bus_word[7:0]),
		.parity_lane_low_in(bus_word[8]), .data_lane_high_in(bus_word[16:9]),
		.parity_lane_high_in(bus_word[17]), .data_lane_low_out(got[7:0]),
		.parity_lane_low_out(got[8]), .data_lane_high_out(got[16:9]),
		.parity_lane_high_out(got[17]), .data_bus_oe);
	pss_ctrl_model peer (.ref_clk, .sys_rst, .clock_hold_n, .wr_issue, .wr_word, .bus_word);

	// ==========
	// Compare and verdict
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// ==========
	// One command per cycle; shadow array gives expected read data
	task automatic cmd(input int k, input logic [20:0] a, input logic [1:0] ln = 2'b00,
		input logic [17:0] w = '0);
		logic [20:0] ea;
		int          op;
		@(negedge ref_clk);
		ea = a;
		op = (k == OP_BST) ? last_op : k;
		if (k == OP_BST) begin
			cnt++;
			ea = {base[20:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
		end else begin
			base = a;
			cnt = 2'b00;
			last_op = k;
		end
		clock_hold_n = 1'b0;
		advance_or_load = (k == OP_BST);
		read_not_write = (k == OP_BST) ? (op != OP_RD) : (k == OP_RD);
		chip_select_first = (k == OP_DES && a == 0) || (k == OP_BST);
		chip_select_second = !(k == OP_DES && a == 1);
		chip_select_third = (k == OP_DES && a == 2);
		{address_upper, burst_seed_bit1, burst_seed_bit0} = (k == OP_BST) ? ~a : a;
		{lane_high_write_en_n, lane_low_write_en_n} = ln;
		wr_issue = (op == OP_WR);
		wr_word = w;
		if (op == OP_WR && !ln[0]) shadow[ea][8:0] = w[8:0];
		if (op == OP_WR && !ln[1]) shadow[ea][17:9] = w[17:9];
		if (op == OP_RD) due.push_back('{run_cnt + 3, shadow[ea]});
	endtask : cmd

	task automatic hold(input int n);
		@(negedge ref_clk);
		clock_hold_n = 1'b1;
		repeat (n - 1) @(negedge ref_clk);
	endtask : hold

	// ==========
	// Bus monitor, counts only edges that are not held
	always @(posedge ref_clk) begin
		if (!sys_rst && !clock_hold_n) run_cnt <= run_cnt + 1;
	end
	always @(negedge ref_clk) begin
		#5;
		if (run_cnt != seen) begin
			seen = run_cnt;
			hit = due.size() > 0 && due[0].t == run_cnt;
			if (hit) exp_d = due[0].d;
			if (hit) due.delete(0);
		end
		chk({17'h0_0000, data_bus_oe}, {17'h0_0000, hit & ~output_enable_n});
		if (hit) chk(got, exp_d);
	end

	// ==========
	// Main sequence
	initial begin
		{sys_rst, chip_select_first, chip_select_second, burst_order_select, ord} = '1;
		{clock_hold_n, chip_select_third, advance_or_load, read_not_write} = '0;
		{lane_low_write_en_n, lane_high_write_en_n, output_enable_n, wr_issue} = '0;
		{address_upper, burst_seed_bit1, burst_seed_bit0, wr_word, base, cnt} = '0;
		last_op = OP_DES;
		repeat (5) @(negedge ref_clk);
		sys_rst = 1'b0;
		cmd(OP_WR, 21'h00_0005, 2'b00, 18'h2_A55A);
		cmd(OP_RD, 21'h00_0005);
		cmd(OP_WR, 21'h1F_FFFF, 2'b00, 18'h3_FFFF);
		cmd(OP_RD, 21'h1F_FFFF);
		cmd(OP_WR, 21'h00_0005, 2'b10, 18'h0_01C3);
		cmd(OP_WR, 21'h00_0005, 2'b01, 18'h3_FE00);
		cmd(OP_WR, 21'h00_0005, 2'b11, 18'h1_2345);
		cmd(OP_RD, 21'h00_0005);
		for (int i = 0; i < 3; i++) begin
			cmd(OP_RD, 21'h1F_FFFF);
			cmd(OP_DES, i);
		end
		burst_order_select = 1'b0;
		ord = 1'b0;
		repeat (3) cmd(OP_DES, 0);
		cmd(OP_WR, 21'h1F_FFFE, 2'b00, 18'h0_BEEF);
		for (int i = 1; i < 4; i++) cmd(OP_BST, 0, 2'b00, {i[1:0], 16'hBEEF});
		burst_order_select = 1'b1;
		ord = 1'b1;
		repeat (3) cmd(OP_DES, 1);
		cmd(OP_RD, 21'h1F_FFFD);
		repeat (2) cmd(OP_BST, 0);
		hold(2);
		repeat (3) cmd(OP_BST, 0);
		cmd(OP_RD, 21'h00_0005);
		hold(3);
		cmd(OP_WR, 21'h00_0005, 2'b00, 18'h0_0ABC);
		hold(1);
		cmd(OP_RD, 21'h00_0005);
		cmd(OP_DES, 2);
		repeat (2) @(negedge ref_clk);
		output_enable_n = 1'b1;
		@(negedge ref_clk);
		output_enable_n = 1'b0;
		repeat (2) cmd(OP_BST, 0);
		repeat (4) cmd(OP_DES, 0);
		give_verdict();
	end

	// Sequence needs about 55 cycles; cut off far beyond that
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
endmodule : pss_sram_tb_top

// >>> verilog/pss_mem.sv
// Storage array, one memory per byte lane, registered read data.
// Assumes the caller gates both ports with the clock hold.
`timescale 1ns/1ps
module pss_mem
	import pss_pkg::*;
(
	input wire logic ref_clk,
	pss_mem_if.mem   port
);

	// ============================================================
	// Lane arrays
	genvar l;
	generate
		for (l = 0; l < PSS_LANES; l++) begin : g_lane
			logic [PSS_LANE_W-1:0] cells [PSS_DEPTH];
			logic [PSS_LANE_W-1:0] q_reg;

			always_ff @(posedge ref_clk) begin
				if (port.wr_en && port.wr_lane[l]) begin
					cells[port.wr_addr] <= port.wr_data[l*PSS_LANE_W +: PSS_LANE_W];
				end
			end

			always_ff @(posedge ref_clk) begin
				if (port.rd_en) begin
					q_reg <= cells[port.rd_addr];
				end
			end

			assign port.rd_data[l*PSS_LANE_W +: PSS_LANE_W] = q_reg;
		end
	endgenerate

endmodule : pss_mem

// >>> verilog/pss_sram.sv
// Pipelined synchronous static memory with late write and burst counter.
// Assumes the controller shares ref_clk; only burst order select and output enable are asynchronous.
`timescale 1ns/1ps
module pss_sram
	import pss_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    clock_hold_n,
	input  wire logic                    chip_select_first,
	input  wire logic                    chip_select_second,
	input  wire logic                    chip_select_third,
	input  wire logic                    advance_or_load,
	input  wire logic                    read_not_write,
	input  wire logic                    lane_low_write_en_n,
	input  wire logic                    lane_high_write_en_n,
	input  wire logic                    output_enable_n,
	input  wire logic                    burst_order_select,
	input  wire logic [PSS_ADDR_W-3:0]   address_upper,
	input  wire logic                    burst_seed_bit1,
	input  wire logic                    burst_seed_bit0,
	input  wire logic [PSS_DATA_BITS-1:0] data_lane_low_in,
	input  wire logic                    parity_lane_low_in,
	input  wire logic [PSS_DATA_BITS-1:0] data_lane_high_in,
	input  wire logic                    parity_lane_high_in,
	output logic      [PSS_DATA_BITS-1:0] data_lane_low_out,
	output logic                         parity_lane_low_out,
	output logic      [PSS_DATA_BITS-1:0] data_lane_high_out,
	output logic                         parity_lane_high_out,
	output logic                         data_bus_oe
);

	// ============================================================
	// Command decode
	logic                    en;
	logic                    chip_on;
	logic                    order_meta_reg;
	logic                    order_reg;
	pss_op_t                 op_next;
	logic [PSS_ADDR_W-1:0]   addr_next;
	logic [PSS_LANES-1:0]    lane_next;
	logic [PSS_WORD_W-1:0]   bus_in;

	pss_op_t                 burst_op_reg;
	logic [PSS_ADDR_W-3:0]   burst_base_reg;
	logic [PSS_BURST_W-1:0]  burst_seed_reg;
	logic [PSS_BURST_W-1:0]  burst_cnt_reg;
	logic [PSS_BURST_W-1:0]  burst_cnt_next;

	assign en      = ~clock_hold_n;
	assign chip_on = ~chip_select_first & chip_select_second & ~chip_select_third;
	assign burst_cnt_next = PSS_BURST_W'(burst_cnt_reg + PSS_BURST_ONE);
	assign lane_next = ~{lane_high_write_en_n, lane_low_write_en_n};
	assign bus_in = {parity_lane_high_in, data_lane_high_in,
	                 parity_lane_low_in, data_lane_low_in};

	always_comb begin
		if (advance_or_load) begin
			op_next   = burst_op_reg;
			addr_next = {burst_base_reg,
			             pss_burst_low(burst_seed_reg, burst_cnt_next, order_reg)};
		end else begin
			if (!chip_on) begin
				op_next = PSS_OP_IDLE;
			end else if (read_not_write) begin
				op_next = PSS_OP_READ;
			end else begin
				op_next = PSS_OP_WRITE;
			end
			addr_next = {address_upper, burst_seed_bit1, burst_seed_bit0};
		end
	end

	// ============================================================
	// Burst order select synchroniser
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			order_meta_reg <= PSS_ORDER_RST;
			order_reg      <= PSS_ORDER_RST;
		end else begin
			order_meta_reg <= burst_order_select;
			order_reg      <= order_meta_reg;
		end
	end

	// ============================================================
	// Burst counter
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			burst_op_reg   <= PSS_OP_IDLE;
			burst_base_reg <= '0;
			burst_seed_reg <= PSS_BURST_ZERO;
			burst_cnt_reg  <= PSS_BURST_ZERO;
		end else if (en && !advance_or_load) begin
			burst_op_reg   <= op_next;
			burst_base_reg <= address_upper;
			burst_seed_reg <= {burst_seed_bit1, burst_seed_bit0};
			burst_cnt_reg  <= PSS_BURST_ZERO;
		end else if (en) begin
			burst_cnt_reg  <= burst_cnt_next;
		end
	end

	// ============================================================
	// Two-stage command pipeline
	pss_op_t                 s1_op_reg;
	pss_op_t                 s2_op_reg;
	logic [PSS_ADDR_W-1:0]   s1_addr_reg;
	logic [PSS_ADDR_W-1:0]   s2_addr_reg;
	logic [PSS_LANES-1:0]    s1_lane_reg;
	logic [PSS_LANES-1:0]    s2_lane_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s1_op_reg   <= PSS_OP_IDLE;
			s2_op_reg   <= PSS_OP_IDLE;
			s1_addr_reg <= '0;
			s2_addr_reg <= '0;
			s1_lane_reg <= '0;
			s2_lane_reg <= '0;
		end else if (en) begin
			s1_op_reg   <= op_next;
			s1_addr_reg <= addr_next;
			s1_lane_reg <= lane_next;
			s2_op_reg   <= s1_op_reg;
			s2_addr_reg <= s1_addr_reg;
			s2_lane_reg <= s1_lane_reg;
		end
	end

	// ============================================================
	// Array access
	pss_mem_if mif ();

	pss_mem u_mem (
		.ref_clk (ref_clk),
		.port    (mif.mem)
	);

	assign mif.rd_en   = en && (s1_op_reg == PSS_OP_READ);
	assign mif.rd_addr = s1_addr_reg;
	assign mif.wr_en   = en && (s2_op_reg == PSS_OP_WRITE);
	assign mif.wr_addr = s2_addr_reg;
	assign mif.wr_lane = s2_lane_reg;
	assign mif.wr_data = bus_in;

	// ============================================================
	// Forwarding of a write landing as its read looks up the array
	logic                    fwd_hit_reg;
	logic [PSS_LANES-1:0]    fwd_lane_reg;
	logic [PSS_WORD_W-1:0]   fwd_data_reg;
	logic [PSS_WORD_W-1:0]   merged;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fwd_hit_reg  <= 1'h0;
			fwd_lane_reg <= '0;
			fwd_data_reg <= '0;
		end else if (en) begin
			fwd_hit_reg  <= (s1_op_reg == PSS_OP_READ) && (s2_op_reg == PSS_OP_WRITE)
			                && (s1_addr_reg == s2_addr_reg);
			fwd_lane_reg <= s2_lane_reg;
			fwd_data_reg <= bus_in;
		end
	end

	genvar g;
	generate
		for (g = 0; g < PSS_LANES; g++) begin : g_merge
			assign merged[g*PSS_LANE_W +: PSS_LANE_W] = (fwd_hit_reg && fwd_lane_reg[g]) ?
				fwd_data_reg[g*PSS_LANE_W +: PSS_LANE_W] :
				mif.rd_data[g*PSS_LANE_W +: PSS_LANE_W];
		end
	endgenerate

	// ============================================================
	// Output stage
	logic                    drive_reg;
	logic [PSS_WORD_W-1:0]   dout_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			drive_reg <= 1'h0;
			dout_reg  <= '0;
		end else if (en) begin
			drive_reg <= (s2_op_reg == PSS_OP_READ);
			dout_reg  <= merged;
		end
	end

	assign data_lane_low_out    = dout_reg[PSS_DATA_BITS-1:0];
	assign parity_lane_low_out  = dout_reg[PSS_LANE_W-1];
	assign data_lane_high_out   = dout_reg[PSS_LANE_W +: PSS_DATA_BITS];
	assign parity_lane_high_out = dout_reg[PSS_WORD_W-1];
	// Output enable gates drivers without a clock
	assign data_bus_oe = drive_reg & ~output_enable_n;

	// ============================================================
	// Checks
	logic ld_read;
	logic ld_write;
	logic ld_idle;
	assign ld_read  = !advance_or_load && chip_on && read_not_write;
	assign ld_write = !advance_or_load && chip_on && !read_not_write;
	assign ld_idle  = !advance_or_load && !chip_on;

	AST_READ_LAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ld_read && en) ##1 en ##1 en |-> ##1 drive_reg)
		else $error("read data not driven two cycles after command");

	AST_WRITE_LAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ld_write && en) ##1 en ##1 en |-> mif.wr_en && mif.wr_addr == $past(addr_next, 2))
		else $error("write not committed two cycles after command");

	AST_LANES: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ld_write && en) ##1 en ##1 en |-> mif.wr_lane == $past(lane_next, 2))
		else $error("lane enables not carried with write");

	AST_DESELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ld_idle && en) ##1 en ##1 en |-> ##1 !drive_reg)
		else $error("bus driven after deselect latency");

	AST_OE_ASYNC: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(en && s2_op_reg == PSS_OP_READ) |=> data_bus_oe == !output_enable_n)
		else $error("bus drive does not follow output enable during read");

	AST_STALL: assert property (@(posedge ref_clk) disable iff (sys_rst)
		clock_hold_n |=> $stable(s2_op_reg) && $stable(drive_reg) && $stable(burst_cnt_reg))
		else $error("state advanced during clock hold");

	AST_BURST_IL: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!advance_or_load && en) ##1 (advance_or_load && en && order_reg) |->
		addr_next[1:0] == ($past(addr_next[1:0]) ^ PSS_BURST_ONE))
		else $error("interleaved burst step wrong");

	AST_BURST_LIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!advance_or_load && en) ##1 (advance_or_load && en && !order_reg) |->
		addr_next[1:0] == PSS_BURST_W'($past(addr_next[1:0]) + PSS_BURST_ONE))
		else $error("linear burst step wrong");

	AST_BURST_UPPER: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!advance_or_load && en) ##1 (advance_or_load && en) |->
		addr_next[PSS_ADDR_W-1:2] == $past(address_upper))
		else $error("burst changed upper address bits");

endmodule : pss_sram
